// ===== design/xcvr_pkg.sv
`default_nettype none
package xcvr_pkg;

    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int PAR_W = 2;
    localparam int ADDR_W = 12;
    localparam int APB_W = 32;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;

    // control fields and reset values
    localparam int CTRL_SENSE_POS = 0;
    localparam int CTRL_GEN_POS = 1;
    localparam logic CTRL_SENSE_RESET = 1'h0;
    localparam logic CTRL_GEN_RESET = 1'h0;

    // status fields
    localparam int ST_AB_PULL_POS = 0;
    localparam int ST_BA_PULL_POS = 1;
    localparam int ST_AB_DRIVE_POS = 2;
    localparam int ST_BA_DRIVE_POS = 3;
    localparam int ST_B_FLAG_LOW_POS = 4;
    localparam int ST_A_FLAG_LOW_POS = 5;
    localparam logic [APB_W-1:0] RDATA_RESET = 32'h0000_0000;

    // synchronised pin levels
    typedef struct packed {
        logic [DATA_W-1:0] a_data;
        logic [DATA_W-1:0] b_data;
        logic [PAR_W-1:0] a_par;
        logic [PAR_W-1:0] b_par;
        logic oe_ab_n;
        logic oe_ba_n;
        logic le_ab;
        logic le_ba;
        logic clk_ab;
        logic clk_ba;
        logic flag_a;
        logic flag_b;
    } pin_s;

    localparam int PIN_W = $bits(pin_s);

    // idle pin levels: outputs disabled, flags released
    localparam pin_s PIN_IDLE = '{oe_ab_n: 1'b1, oe_ba_n: 1'b1,
        flag_a: 1'b1, flag_b: 1'b1, default: '0};

    typedef struct packed {
        logic oe_n;
        logic le;
        logic rise;
    } dir_ctrl_s;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [PAR_W-1:0] par;
        logic drive;
        logic pull;
    } path_out_s;

    function automatic logic [PAR_W-1:0] gen_bits(
        input logic [DATA_W-1:0] d, input logic sense);
        logic [PAR_W-1:0] r;
        r = '0;
        for (int i = 0; i < PAR_W; i++) begin
            r[i] = (^d[i*BYTE_W +: BYTE_W]) ^ sense;
        end
        return r;
    endfunction : gen_bits

    function automatic logic [PAR_W-1:0] chk_errs(
        input logic [DATA_W-1:0] d, input logic [PAR_W-1:0] p,
        input logic sense);
        logic [PAR_W-1:0] r;
        r = '0;
        for (int i = 0; i < PAR_W; i++) begin
            r[i] = (^{d[i*BYTE_W +: BYTE_W], p[i]}) ^ sense;
        end
        return r;
    endfunction : chk_errs

endpackage : xcvr_pkg
`default_nettype wire

// ===== design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
    import xcvr_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // raw pins and their filtered levels
    input wire pin_s raw,
    output var pin_s stable
);

    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] held;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s1 <= PIN_IDLE;
            s2 <= PIN_IDLE;
            s3 <= PIN_IDLE;
        end else begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a bit moves only once stages two and three agree
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            held <= PIN_IDLE;
        end else begin
            held <= (s3 & ~(s2 ^ s3)) | (held & (s2 ^ s3));
        end
    end

    assign stable = pin_s'(held);

endmodule : pin_sync
`default_nettype wire

// ===== design/xfer_path.sv
`timescale 1ns/1ps
`default_nettype none
module xfer_path
    import xcvr_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // direction controls and selects
    input wire dir_ctrl_s ctl,
    input wire logic gen,
    input wire logic sense,
    // source side
    input wire logic [DATA_W-1:0] data,
    input wire logic [PAR_W-1:0] par,
    // destination side
    output var path_out_s q
);

    logic [DATA_W-1:0] held_data;
    logic [PAR_W-1:0] held_par;
    logic held_err;
    logic drive;
    logic pull;
    logic load;
    logic [PAR_W-1:0] next_par;
    logic next_err;

    // received parity ignored while generating
    always_comb begin
        load = ctl.le | ctl.rise;
        next_par = gen ? gen_bits(data, sense) : par;
        next_err = gen ? 1'b0 : |chk_errs(data, par, sense);
    end

    // data, parity and result share one store
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            held_data <= '0;
            held_par <= '0;
            held_err <= 1'b0;
        end else if (load) begin
            held_data <= data;
            held_par <= next_par;
            held_err <= next_err;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            drive <= 1'b0;
            pull <= 1'b0;
        end else begin
            drive <= ~ctl.oe_n;
            pull <= ~ctl.oe_n & (load ? next_err : held_err);
        end
    end

    assign q = '{data: held_data, par: held_par, drive: drive, pull: pull};

endmodule : xfer_path
`default_nettype wire

// ===== design/parity_transceiver.sv
// How it works
// - B data and parity are driven only while the A-to-B enable is low.
// - latch enable high makes B outputs follow the A inputs.
// - with latch enable low, a rising A-to-B clock captures A data.
// - with latch enable low and no rising clock, B outputs hold.
// - the B-to-A path behaves the same under its own controls.
// - bits 0-7 pair with parity bit 0, bits 8-15 with bit 1.
// - generate mode drives B parity from each A byte, sense-selected.
// - check mode flags a byte whose ones count breaks the sense.
// - check mode forwards received parity bits unchanged with the data.
// - the B-side flag pulls low on an error in either A-to-B byte.
// - the B-side flag stays released while A-to-B generates.
// - A parity inputs are ignored while A-to-B generates parity.
// - B-to-A always checks and reports on the A-side flag.
// - B-to-A checking runs alongside A-to-B generation.
// - each flag can pull only while its direction is enabled.
// - one sense select is shared; otherwise directions are independent.
// - the generate select affects only the A-to-B direction.
// - parity bits and results pass through the same store as data.
// - each port is input one way and tri-state output the other.
`timescale 1ns/1ps
`default_nettype none
module parity_transceiver
    import xcvr_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [APB_W-1:0] pwdata,
    output logic [APB_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // a port
    input wire logic [DATA_W-1:0] a_port_data,
    output logic [DATA_W-1:0] a_port_data_drive,
    output logic a_port_data_oe,
    input wire logic [PAR_W-1:0] a_side_parity_bits,
    output logic [PAR_W-1:0] a_side_parity_bits_drive,
    output logic a_side_parity_bits_oe,
    // b port
    input wire logic [DATA_W-1:0] b_port_data,
    output logic [DATA_W-1:0] b_port_data_drive,
    output logic b_port_data_oe,
    input wire logic [PAR_W-1:0] b_side_parity_bits,
    output logic [PAR_W-1:0] b_side_parity_bits_drive,
    output logic b_side_parity_bits_oe,
    // direction controls
    input wire logic a_to_b_output_enable_n,
    input wire logic b_to_a_output_enable_n,
    input wire logic a_to_b_latch_enable,
    input wire logic b_to_a_latch_enable,
    input wire logic a_to_b_clock,
    input wire logic b_to_a_clock,
    // open-drain error flags
    input wire logic a_side_parity_error_n,
    output logic a_side_parity_error_n_drive,
    output logic a_side_parity_error_n_oe,
    input wire logic b_side_parity_error_n,
    output logic b_side_parity_error_n_drive,
    output logic b_side_parity_error_n_oe
);

    pin_s raw;
    pin_s pins;
    logic [1:0] clk_prev;
    logic [1:0] rise;
    dir_ctrl_s ab_ctl;
    dir_ctrl_s ba_ctl;
    path_out_s ab_q;
    path_out_s ba_q;
    logic parity_sense_select;
    logic generate_or_check_select;
    logic [APB_W-1:0] next_prdata;
    logic hit;
    logic wr_ctrl;
    logic flag_low;

    // every pin enters through the filter
    always_comb begin
        raw.a_data = a_port_data;
        raw.b_data = b_port_data;
        raw.a_par = a_side_parity_bits;
        raw.b_par = b_side_parity_bits;
        raw.oe_ab_n = a_to_b_output_enable_n;
        raw.oe_ba_n = b_to_a_output_enable_n;
        raw.le_ab = a_to_b_latch_enable;
        raw.le_ba = b_to_a_latch_enable;
        raw.clk_ab = a_to_b_clock;
        raw.clk_ba = b_to_a_clock;
        raw.flag_a = a_side_parity_error_n;
        raw.flag_b = b_side_parity_error_n;
    end

    pin_sync u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .raw(raw),
        .stable(pins)
    );

    // a clock already high when the latch closes gives no edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            clk_prev <= 2'h3;
        end else begin
            clk_prev <= {pins.clk_ba, pins.clk_ab};
        end
    end

    always_comb begin
        rise = {pins.clk_ba, pins.clk_ab} & ~clk_prev;
        ab_ctl = '{oe_n: pins.oe_ab_n, le: pins.le_ab, rise: rise[0]};
        ba_ctl = '{oe_n: pins.oe_ba_n, le: pins.le_ba, rise: rise[1]};
    end

    xfer_path u_ab (
        .core_clk(core_clk),
        .nrst(nrst),
        .ctl(ab_ctl),
        .gen(~generate_or_check_select),
        .sense(parity_sense_select),
        .data(pins.a_data),
        .par(pins.a_par),
        .q(ab_q)
    );

    // reverse path never generates
    xfer_path u_ba (
        .core_clk(core_clk),
        .nrst(nrst),
        .ctl(ba_ctl),
        .gen(1'b0),
        .sense(parity_sense_select),
        .data(pins.b_data),
        .par(pins.b_par),
        .q(ba_q)
    );

    assign b_port_data_drive = ab_q.data;
    assign b_side_parity_bits_drive = ab_q.par;
    assign b_port_data_oe = ab_q.drive;
    assign b_side_parity_bits_oe = ab_q.drive;
    assign b_side_parity_error_n_oe = ab_q.pull;
    assign a_port_data_drive = ba_q.data;
    assign a_side_parity_bits_drive = ba_q.par;
    assign a_port_data_oe = ba_q.drive;
    assign a_side_parity_bits_oe = ba_q.drive;
    assign a_side_parity_error_n_oe = ba_q.pull;
    assign a_side_parity_error_n_drive = flag_low;
    assign b_side_parity_error_n_drive = flag_low;

    // open-drain pins only ever pull low
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flag_low <= 1'b0;
        end else begin
            flag_low <= 1'b0;
        end
    end

    // apb decode
    always_comb begin
        hit = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET);
        wr_ctrl = psel && penable && pready && pwrite
            && (paddr == CTRL_OFFSET);
        next_prdata = RDATA_RESET;
        if (paddr == CTRL_OFFSET) begin
            next_prdata[CTRL_SENSE_POS] = parity_sense_select;
            next_prdata[CTRL_GEN_POS] = generate_or_check_select;
        end else if (paddr == STATUS_OFFSET) begin
            next_prdata[ST_AB_PULL_POS] = ab_q.pull;
            next_prdata[ST_BA_PULL_POS] = ba_q.pull;
            next_prdata[ST_AB_DRIVE_POS] = ab_q.drive;
            next_prdata[ST_BA_DRIVE_POS] = ba_q.drive;
            next_prdata[ST_B_FLAG_LOW_POS] = ~pins.flag_b;
            next_prdata[ST_A_FLAG_LOW_POS] = ~pins.flag_a;
        end
    end

    // one wait-free access phase per transfer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= RDATA_RESET;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? RDATA_RESET : next_prdata;
            pslverr <= !hit;
        end
    end

    // shared sense select, generate select for a-to-b only
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            parity_sense_select <= CTRL_SENSE_RESET;
            generate_or_check_select <= CTRL_GEN_RESET;
        end else if (wr_ctrl) begin
            parity_sense_select <= pwdata[CTRL_SENSE_POS];
            generate_or_check_select <= pwdata[CTRL_GEN_POS];
        end
    end

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_answer;
        pready ##1 !pready;
    endsequence

    sequence s_capture_ab;
        rise[0] && !pins.le_ab;
    endsequence

    sequence s_idle_ab;
        !rise[0] && !pins.le_ab;
    endsequence

    property p_apb_answer;
        @(posedge core_clk) disable iff (!nrst)
        s_setup |=> s_answer;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer not one cycle after setup");

    property p_b_hiz;
        @(posedge core_clk) disable iff (!nrst)
        pins.oe_ab_n |=> !b_port_data_oe && !b_side_parity_bits_oe;
    endproperty
    a_b_hiz: assert property (p_b_hiz)
        else $error("b port driven while disabled");

    property p_ab_pass;
        @(posedge core_clk) disable iff (!nrst)
        pins.le_ab |=> b_port_data_drive == $past(pins.a_data);
    endproperty
    a_ab_pass: assert property (p_ab_pass)
        else $error("b data does not follow a in pass mode");

    property p_ab_capture;
        @(posedge core_clk) disable iff (!nrst)
        s_capture_ab |=> b_port_data_drive == $past(pins.a_data);
    endproperty
    a_ab_capture: assert property (p_ab_capture)
        else $error("a data not captured on clock edge");

    property p_ab_hold;
        @(posedge core_clk) disable iff (!nrst)
        s_idle_ab ##1 s_idle_ab |-> $stable(b_port_data_drive)
            && $stable(b_side_parity_bits_drive);
    endproperty
    a_ab_hold: assert property (p_ab_hold)
        else $error("b outputs changed while latched");

    property p_ba_pass;
        @(posedge core_clk) disable iff (!nrst)
        (pins.le_ba || rise[1]) && !pins.oe_ba_n |=> a_port_data_oe
            && a_port_data_drive == $past(pins.b_data);
    endproperty
    a_ba_pass: assert property (p_ba_pass)
        else $error("a data wrong in b-to-a pass");

    property p_gen_par;
        @(posedge core_clk) disable iff (!nrst)
        pins.le_ab && !generate_or_check_select
            |=> b_side_parity_bits_drive == gen_bits($past(pins.a_data),
                $past(parity_sense_select));
    endproperty
    a_gen_par: assert property (p_gen_par)
        else $error("generated parity wrong");

    property p_fwd_par;
        @(posedge core_clk) disable iff (!nrst)
        pins.le_ab && generate_or_check_select
            |=> b_side_parity_bits_drive == $past(pins.a_par);
    endproperty
    a_fwd_par: assert property (p_fwd_par)
        else $error("checked parity not forwarded");

    property p_chk_ab;
        @(posedge core_clk) disable iff (!nrst)
        (pins.le_ab || rise[0]) && generate_or_check_select
            && !pins.oe_ab_n |=> b_side_parity_error_n_oe
            == |chk_errs($past(pins.a_data), $past(pins.a_par),
                $past(parity_sense_select));
    endproperty
    a_chk_ab: assert property (p_chk_ab)
        else $error("a-to-b error flag wrong");

    property p_gen_quiet;
        @(posedge core_clk) disable iff (!nrst)
        (pins.le_ab || rise[0]) && !generate_or_check_select
            |=> !b_side_parity_error_n_oe;
    endproperty
    a_gen_quiet: assert property (p_gen_quiet)
        else $error("error flag pulled during generation");

    property p_chk_ba;
        @(posedge core_clk) disable iff (!nrst)
        pins.le_ba && !pins.oe_ba_n |=> a_side_parity_error_n_oe
            == |chk_errs($past(pins.b_data), $past(pins.b_par),
                $past(parity_sense_select));
    endproperty
    a_chk_ba: assert property (p_chk_ba)
        else $error("b-to-a error flag wrong");

    property p_chk_ba_clk;
        @(posedge core_clk) disable iff (!nrst)
        rise[1] && !pins.le_ba && !pins.oe_ba_n |=> a_side_parity_error_n_oe
            == |chk_errs($past(pins.b_data), $past(pins.b_par),
                $past(parity_sense_select));
    endproperty
    a_chk_ba_clk: assert property (p_chk_ba_clk)
        else $error("b-to-a flag not captured on clock edge");

    property p_flag_oe;
        @(posedge core_clk) disable iff (!nrst)
        pins.oe_ab_n && pins.oe_ba_n |=> !a_side_parity_error_n_oe
            && !b_side_parity_error_n_oe;
    endproperty
    a_flag_oe: assert property (p_flag_oe)
        else $error("error flag pulled while disabled");

    property p_od_low;
        @(posedge core_clk) disable iff (!nrst)
        a_side_parity_error_n_oe || b_side_parity_error_n_oe
            |-> !a_side_parity_error_n_drive
            && !b_side_parity_error_n_drive;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("open-drain flag drives high");

endmodule : parity_transceiver
`default_nettype wire

// ===== bench/bus_party.sv
`timescale 1ns/1ps
`default_nettype none
module bus_party
    import xcvr_pkg::*;
(
    // clock
    input wire logic core_clk,
    // far-side traffic
    input wire logic a_en,
    input wire logic b_en,
    input wire logic [DATA_W-1:0] a_send,
    input wire logic [DATA_W-1:0] b_send,
    input wire logic [PAR_W-1:0] a_psend,
    input wire logic [PAR_W-1:0] b_psend,
    // device drivers
    input wire logic [DATA_W-1:0] a_drv,
    input wire logic [DATA_W-1:0] b_drv,
    input wire logic [PAR_W-1:0] a_pdrv,
    input wire logic [PAR_W-1:0] b_pdrv,
    input wire logic a_oe,
    input wire logic b_oe,
    input wire logic a_poe,
    input wire logic b_poe,
    input wire logic a_fdrv,
    input wire logic b_fdrv,
    input wire logic a_foe,
    input wire logic b_foe,
    // resolved wires
    output logic [DATA_W-1:0] a_wire,
    output logic [DATA_W-1:0] b_wire,
    output logic [PAR_W-1:0] a_pwire,
    output logic [PAR_W-1:0] b_pwire,
    output logic a_fwire,
    output logic b_fwire
);
    // a released bus shows a pattern that flips every cycle
    logic [DATA_W+PAR_W-1:0] a_idle = '0;
    logic [DATA_W+PAR_W-1:0] b_idle = '0;
    always_ff @(posedge core_clk) begin
        a_idle <= ~{a_wire, a_pwire};
        b_idle <= ~{b_wire, b_pwire};
    end
    // the party yields a port while the device drives it
    assign a_wire = a_oe ? a_drv : a_en ? a_send : a_idle[17:2];
    assign b_wire = b_oe ? b_drv : b_en ? b_send : b_idle[17:2];
    assign a_pwire = a_poe ? a_pdrv : a_en ? a_psend : a_idle[1:0];
    assign b_pwire = b_poe ? b_pdrv : b_en ? b_psend : b_idle[1:0];
    // pull-ups on the open-drain flags
    assign a_fwire = a_foe ? a_fdrv : 1'b1;
    assign b_fwire = b_foe ? b_fdrv : 1'b1;
endmodule : bus_party
`default_nettype wire

// ===== bench/registered_parity_transceiver_test.sv
`timescale 1ns/1ps
`default_nettype none
module registered_parity_transceiver_test
    import xcvr_pkg::*;
();
    logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, er;
    logic [ADDR_W-1:0] paddr;
    logic [APB_W-1:0] pwdata, prdata, rd;
    logic [DATA_W-1:0] a_send, b_send, a_wire, b_wire, a_drv, b_drv;
    logic [PAR_W-1:0] a_psend, b_psend, a_pwire, b_pwire, a_pdrv, b_pdrv;
    logic a_en, b_en, a_oe, b_oe, a_poe, b_poe, oe_ab_n, oe_ba_n;
    logic le_ab, le_ba, clk_ab, clk_ba;
    logic a_fwire, b_fwire, a_fdrv, b_fdrv, a_foe, b_foe;
    int n_mismatch, compares;
    logic [31:0] seed;
    // reference model state
    logic [DATA_W-1:0] m_ab_d, m_ba_d;
    logic [PAR_W-1:0] m_ab_p, m_ba_p;
    logic m_ab_e, m_ba_e, m_ab_clk, m_ba_clk, sense, gen;

    parity_transceiver u_parity_transceiver(.core_clk(core_clk),
        .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .a_port_data(a_wire), .a_port_data_drive(a_drv),
        .a_port_data_oe(a_oe), .a_side_parity_bits(a_pwire),
        .a_side_parity_bits_drive(a_pdrv), .a_side_parity_bits_oe(a_poe),
        .b_port_data(b_wire), .b_port_data_drive(b_drv),
        .b_port_data_oe(b_oe), .b_side_parity_bits(b_pwire),
        .b_side_parity_bits_drive(b_pdrv), .b_side_parity_bits_oe(b_poe),
        .a_to_b_output_enable_n(oe_ab_n), .b_to_a_output_enable_n(oe_ba_n),
        .a_to_b_latch_enable(le_ab), .b_to_a_latch_enable(le_ba),
        .a_to_b_clock(clk_ab), .b_to_a_clock(clk_ba),
        .a_side_parity_error_n(a_fwire), .a_side_parity_error_n_drive(a_fdrv),
        .a_side_parity_error_n_oe(a_foe), .b_side_parity_error_n(b_fwire),
        .b_side_parity_error_n_drive(b_fdrv), .b_side_parity_error_n_oe(b_foe));
    bus_party u_bus_party(.core_clk(core_clk), .a_en(a_en), .b_en(b_en),
        .a_send(a_send), .b_send(b_send), .a_psend(a_psend),
        .b_psend(b_psend), .a_drv(a_drv), .b_drv(b_drv), .a_pdrv(a_pdrv),
        .b_pdrv(b_pdrv), .a_oe(a_oe), .b_oe(b_oe), .a_poe(a_poe),
        .b_poe(b_poe), .a_fdrv(a_fdrv), .b_fdrv(b_fdrv), .a_foe(a_foe),
        .b_foe(b_foe), .a_wire(a_wire), .b_wire(b_wire), .a_pwire(a_pwire),
        .b_pwire(b_pwire), .a_fwire(a_fwire), .b_fwire(b_fwire));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic odd_byte(input logic [DATA_W-1:0] d, input int i);
        logic r;
        r = 1'b0;
        for (int k = 0; k < BYTE_W; k++) r = r ^ d[i*BYTE_W+k];
        return r;
    endfunction : odd_byte

    task report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: word %h not %h", $time, got, exp);
        end
    endtask : cmp_word

    task cmp_par(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: parity %b not %b", $time, got, exp);
        end
    endtask : cmp_par

    task cmp_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: bit %b not %b", $time, got, exp);
        end
    endtask : cmp_bit

    task apb(input logic wr, input logic [ADDR_W-1:0] ad,
        input logic [APB_W-1:0] wd, output logic [APB_W-1:0] rdat,
        output logic err);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("wrong value at %0t: no pready", $time);
        end
    endtask : apb

    task set_ctrl(input logic g, input logic s);
        logic [31:0] w;
        w = '0;
        w[CTRL_GEN_POS] = g;
        w[CTRL_SENSE_POS] = s;
        gen = g;
        sense = s;
        apb(1'b1, CTRL_OFFSET, w, rd, er);
        apb(1'b0, CTRL_OFFSET, 32'h0, rd, er);
        cmp_word(rd, w);
        cmp_bit(er, 1'b0);
    endtask : set_ctrl

    task check_all();
        logic fab, fba;
        logic [31:0] st;
        if (le_ab || (clk_ab && !m_ab_clk)) begin
            m_ab_d = a_wire;
            m_ab_e = 1'b0;
            for (int i = 0; i < PAR_W; i++) begin
                m_ab_p[i] = gen ? a_pwire[i] : odd_byte(a_wire, i) ^ sense;
                m_ab_e |= gen & (odd_byte(a_wire, i) ^ a_pwire[i] ^ sense);
            end
        end
        if (le_ba || (clk_ba && !m_ba_clk)) begin
            m_ba_d = b_wire;
            m_ba_p = b_pwire;
            m_ba_e = 1'b0;
            for (int i = 0; i < PAR_W; i++) begin
                m_ba_e |= odd_byte(b_wire, i) ^ b_pwire[i] ^ sense;
            end
        end
        m_ab_clk = clk_ab;
        m_ba_clk = clk_ba;
        fab = !oe_ab_n & m_ab_e;
        fba = !oe_ba_n & m_ba_e;
        cmp_bit(b_oe, !oe_ab_n);
        cmp_bit(b_poe, !oe_ab_n);
        cmp_bit(a_oe, !oe_ba_n);
        cmp_bit(a_poe, !oe_ba_n);
        cmp_bit(b_fwire, !fab);
        cmp_bit(a_fwire, !fba);
        if (!oe_ab_n) cmp_word({16'h0000, b_drv}, {16'h0000, m_ab_d});
        if (!oe_ab_n) cmp_par(b_pdrv, m_ab_p);
        if (!oe_ba_n) cmp_word({16'h0000, a_drv}, {16'h0000, m_ba_d});
        if (!oe_ba_n) cmp_par(a_pdrv, m_ba_p);
        st = '0;
        st[ST_AB_PULL_POS] = fab;
        st[ST_BA_PULL_POS] = fba;
        st[ST_AB_DRIVE_POS] = !oe_ab_n;
        st[ST_BA_DRIVE_POS] = !oe_ba_n;
        st[ST_B_FLAG_LOW_POS] = fab;
        st[ST_A_FLAG_LOW_POS] = fba;
        apb(1'b0, STATUS_OFFSET, 32'h0, rd, er);
        cmp_word(rd, st);
    endtask : check_all

    // outputs lag the pins by five edges; status flag bits by nine
    task settle();
        repeat (8) @(posedge core_clk);
        #1;
        check_all();
    endtask : settle

    task drive(input logic ba, input logic le, input logic clk, input logic zero);
        logic [31:0] r;
        r = xs();
        @(posedge core_clk);
        a_en <= !ba;
        b_en <= ba;
        oe_ab_n <= ba;
        oe_ba_n <= !ba;
        le_ab <= !ba & le;
        le_ba <= ba & le;
        clk_ab <= !ba & clk;
        clk_ba <= ba & clk;
        a_send <= zero ? 16'h0000 : r[15:0];
        b_send <= zero ? 16'h0000 : r[31:16];
        a_psend <= r[17:16];
        b_psend <= r[1:0];
        settle();
    endtask : drive

    task off();
        @(posedge core_clk);
        oe_ab_n <= 1'b1;
        oe_ba_n <= 1'b1;
        settle();
    endtask : off

    task t_pass(input logic ba);
        for (int m = 0; m < 4; m++) begin
            set_ctrl(m[1], m[0]);
            for (int k = 0; k < 3; k++) drive(ba, 1'b1, 1'b0, k == 0);
        end
        off();
        $display("test pass direction %0d done", ba);
    endtask : t_pass

    task t_clocked(input logic ba);
        set_ctrl(1'b1, 1'b0);
        for (int i = 0; i < 5; i++) drive(ba, i == 0, i != 2, 1'b0);
        off();
        $display("test clocked direction %0d done", ba);
    endtask : t_clocked

    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        $display("wrong value at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        seed = 32'h6bd5;
        n_mismatch = 0;
        compares = 0;
        nrst = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {a_en, b_en, le_ab, le_ba, clk_ab, clk_ba} = '0;
        {a_send, b_send, a_psend, b_psend} = '0;
        oe_ab_n = 1'b1;
        oe_ba_n = 1'b1;
        {m_ab_d, m_ba_d, m_ab_p, m_ba_p, m_ab_e, m_ba_e} = '0;
        {m_ab_clk, m_ba_clk, sense, gen} = 4'h0;
        m_ab_clk = 1'b1;
        m_ba_clk = 1'b1;
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        apb(1'b0, CTRL_OFFSET, 32'h0, rd, er);
        cmp_word(rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0, rd, er);
        cmp_bit(er, 1'b1);
        cmp_word(rd, 32'h0);
        apb(1'b1, STATUS_OFFSET, 32'hffff_ffff, rd, er);
        cmp_bit(er, 1'b0);
        settle();
        $display("test registers done");
        t_pass(1'b0);
        t_pass(1'b1);
        t_clocked(1'b0);
        t_clocked(1'b1);
        report_and_stop();
    end
endmodule : registered_parity_transceiver_test
`default_nettype wire
